// ==== bccw_pkg.sv ====
// Package with constants and types for the control word format decoder.
package bccw_pkg;
	localparam logic [15:0] BCCW_CFG_REG_ADDR = 16'h0032;
	localparam logic [15:0] BCCW_IEN_REG_ADDR = 16'h0010;
	localparam int BCCW_MASK_MODE_BIT = 0;
	localparam int BCCW_EOM_EN_BIT = 3;
	localparam int BCCW_EXPECT_POS = 5;
	localparam int BCCW_IRQ_POS = 4;
	localparam int BCCW_UNUSED_POS = 3;
	localparam int BCCW_STAT_BCR_POS = 4;
	localparam logic [15:0] BCCW_CTRL_RESET = 16'h0000;

	typedef enum logic [2:0] {
		BCCW_TYPE_BC_RT = 3'h0,
		BCCW_TYPE_RT_BC = 3'h1,
		BCCW_TYPE_RT_RT = 3'h2,
		BCCW_TYPE_BC_BC_RT = 3'h3,
		BCCW_TYPE_BC_RT_RT = 3'h4,
		BCCW_TYPE_MODE = 3'h5,
		BCCW_TYPE_BC_MODE = 3'h6,
		BCCW_TYPE_ILLEGAL = 3'h7
	} bccw_type_t;

	typedef enum logic [0:0] {
		BCCW_IDLE = 1'b0,
		BCCW_BUSY = 1'b1
	} bccw_state_t;

	typedef struct packed {
		logic fmt_mode_code;
		logic fmt_broadcast;
		logic fmt_terminal_to_terminal;
	} bccw_fmt_t;

	typedef struct packed {
		bccw_state_t state;
		logic [15:0] ctrl;
		logic bcast_status_mask_or_expect;
		logic msg_done_irq_request;
		bccw_fmt_t fmt;
		bccw_type_t msg_type;
		logic ext_block;
		logic status_set;
		logic irq;
		logic in_msg;
	} bccw_state_rec_t;
endpackage : bccw_pkg

// ==== bccw_decode.sv ====
// Control word format, broadcast status and end-of-message decode.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - With mask mode clear, control bit 5 is the expected broadcast-received bit.
// - Expected mode: bit 5 differing from status bit 4 flags status-set.
// - Expected mode: matching bit 5 and status bit 4 adds nothing.
// - Interrupt at completion only when control bit 4 and enable bit 3 set.
// - Control bit 3 is ignored and resets to zero.
// - Format 000 gives BC-to-RT or RT-to-BC from the T/R bit.
// - Codes 001,010,011,100,110 decode to their types; 101 and 111 unused.
// - Format bit 0 alone selects the extended 16-word control block.
// - Mask mode: clear bit 5 lets a set status bit 4 flag status-set.
module bccw_decode
	import bccw_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic ctrl_wr_in,
	input wire logic [15:0] ctrl_data_in,
	input wire logic [15:0] cfg_reg_in,
	input wire logic [15:0] irq_en_reg_in,
	input wire logic msg_start_in,
	input wire logic cmd_tr_in,
	input wire logic status_valid_in,
	input wire logic [15:0] status_word_in,
	input wire logic msg_done_in,
	output logic [15:0] ctrl_out,
	output bccw_type_t msg_type_out,
	output logic ext_block_out,
	output logic status_set_out,
	output logic msg_done_irq_out,
	output logic busy_out
);

	////////////////////////////////////////////////////////////////////////
	function automatic bccw_type_t decode_type(input bccw_fmt_t f,
		input logic tr);
		unique case ({f.fmt_mode_code, f.fmt_broadcast,
			f.fmt_terminal_to_terminal})
			3'h0: decode_type = tr ? BCCW_TYPE_RT_BC : BCCW_TYPE_BC_RT;
			3'h1: decode_type = BCCW_TYPE_RT_RT;
			3'h2: decode_type = BCCW_TYPE_BC_BC_RT;
			3'h3: decode_type = BCCW_TYPE_BC_RT_RT;
			3'h4: decode_type = BCCW_TYPE_MODE;
			3'h6: decode_type = BCCW_TYPE_BC_MODE;
			default: decode_type = BCCW_TYPE_ILLEGAL;
		endcase
	endfunction : decode_type

	////////////////////////////////////////////////////////////////////////
	bccw_state_rec_t r_reg;
	bccw_state_rec_t r_next;
	logic bcr_hit;

	always_comb begin
		r_next = r_reg;
		r_next.irq = 1'b0;
		bcr_hit = 1'b0;
		if (ctrl_wr_in) begin
			r_next.ctrl = ctrl_data_in;
			r_next.ctrl[BCCW_UNUSED_POS] = 1'b0;
		end
		unique case (r_reg.state)
			BCCW_IDLE: begin
				if (msg_start_in) begin
					// Latch the word so a rewrite mid-message has no effect.
					r_next.state = BCCW_BUSY;
					r_next.bcast_status_mask_or_expect = r_reg.ctrl[BCCW_EXPECT_POS];
					r_next.msg_done_irq_request = r_reg.ctrl[BCCW_IRQ_POS];
					r_next.fmt = r_reg.ctrl[2:0];
					r_next.msg_type = decode_type(r_reg.ctrl[2:0], cmd_tr_in);
					r_next.ext_block = r_reg.ctrl[0];
					r_next.status_set = 1'b0;
					r_next.in_msg = 1'b1;
				end
			end
			BCCW_BUSY: begin
				if (status_valid_in) begin
					if (cfg_reg_in[BCCW_MASK_MODE_BIT]) begin
						bcr_hit = !r_reg.bcast_status_mask_or_expect
							&& status_word_in[BCCW_STAT_BCR_POS];
					end else begin
						bcr_hit = r_reg.bcast_status_mask_or_expect
							!= status_word_in[BCCW_STAT_BCR_POS];
					end
					r_next.status_set = r_reg.status_set | bcr_hit;
				end
				if (msg_done_in) begin
					r_next.state = BCCW_IDLE;
					r_next.in_msg = 1'b0;
					r_next.irq = r_reg.msg_done_irq_request
						&& irq_en_reg_in[BCCW_EOM_EN_BIT];
				end
			end
		endcase
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign ctrl_out = r_reg.ctrl;
	assign msg_type_out = r_reg.msg_type;
	assign ext_block_out = r_reg.ext_block;
	assign status_set_out = r_reg.status_set;
	assign msg_done_irq_out = r_reg.irq;
	assign busy_out = r_reg.in_msg;

	////////////////////////////////////////////////////////////////////////
	// The interrupt is a single pulse and needs both request and enable.
	a_irq_needs_both: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		msg_done_irq_out |-> $past(r_reg.msg_done_irq_request)
		&& $past(irq_en_reg_in[BCCW_EOM_EN_BIT]))
		else $error("Interrupt without request and enable.");
	a_irq_at_done: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_BUSY && msg_done_in && r_reg.msg_done_irq_request
		&& irq_en_reg_in[BCCW_EOM_EN_BIT]) |=> msg_done_irq_out)
		else $error("Missing end-of-message interrupt.");
	a_irq_one_pulse: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		msg_done_irq_out |=> !msg_done_irq_out)
		else $error("Interrupt held longer than one cycle.");

	// The stored word keeps every bit but the unused one.
	a_unused_bit_zero: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		!ctrl_out[BCCW_UNUSED_POS])
		else $error("Unused control bit is set.");
	a_ctrl_write: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		ctrl_wr_in |=> ctrl_out[15:4] == $past(ctrl_data_in[15:4])
		&& ctrl_out[2:0] == $past(ctrl_data_in[2:0]))
		else $error("Control word write not stored.");

	// Broadcast-received evaluation in both modes.
	a_expect_mismatch: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_BUSY && status_valid_in
		&& !cfg_reg_in[BCCW_MASK_MODE_BIT]
		&& r_reg.bcast_status_mask_or_expect
		!= status_word_in[BCCW_STAT_BCR_POS]) |=> status_set_out)
		else $error("Mismatch did not flag status-set.");
	a_expect_match: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_BUSY && status_valid_in && !status_set_out
		&& !cfg_reg_in[BCCW_MASK_MODE_BIT]
		&& r_reg.bcast_status_mask_or_expect
		== status_word_in[BCCW_STAT_BCR_POS]) |=> !status_set_out)
		else $error("Match flagged status-set.");
	a_mask_mode: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_BUSY && status_valid_in && !status_set_out
		&& cfg_reg_in[BCCW_MASK_MODE_BIT]) |=> status_set_out
		== (!r_reg.bcast_status_mask_or_expect
		&& $past(status_word_in[BCCW_STAT_BCR_POS])))
		else $error("Mask mode status-set wrong.");
	a_mask_ignored: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_BUSY && status_valid_in && !status_set_out
		&& cfg_reg_in[BCCW_MASK_MODE_BIT] && r_reg.bcast_status_mask_or_expect)
		|=> !status_set_out)
		else $error("Masked status bit flagged status-set.");
	a_set_sticky: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_BUSY && status_set_out) |=> status_set_out)
		else $error("Status-set dropped inside a message.");
	a_set_cleared: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_IDLE && msg_start_in) |=> !status_set_out)
		else $error("Status-set not cleared at message start.");
	a_idle_ignores: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_IDLE && !msg_start_in) |=> $stable(status_set_out))
		else $error("Status-set changed while idle.");

	// Format decode and control block selection at message start.
	a_ext_block_bit0: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_IDLE && msg_start_in) |=>
		ext_block_out == $past(ctrl_out[0]))
		else $error("Extended block not from format bit 0.");
	a_held_ext: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_BUSY) |=> $stable(ext_block_out))
		else $error("Extended block select changed mid-message.");
	a_type_decode: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_IDLE && msg_start_in && ctrl_out[2:0] == 3'h0)
		|=> msg_type_out == ($past(cmd_tr_in) ? BCCW_TYPE_RT_BC
		: BCCW_TYPE_BC_RT))
		else $error("Format 000 decoded wrongly.");
	a_rtrt_type: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_IDLE && msg_start_in && ctrl_out[2:0] == 3'h3)
		|=> msg_type_out == BCCW_TYPE_BC_RT_RT)
		else $error("Format 011 decoded wrongly.");
	a_rt_to_rt: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_IDLE && msg_start_in && ctrl_out[2:0] == 3'h1)
		|=> msg_type_out == BCCW_TYPE_RT_RT)
		else $error("Format 001 decoded wrongly.");
	a_bcast_bc_rt: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_IDLE && msg_start_in && ctrl_out[2:0] == 3'h2)
		|=> msg_type_out == BCCW_TYPE_BC_BC_RT)
		else $error("Format 010 decoded wrongly.");
	a_mode_type: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_IDLE && msg_start_in && ctrl_out[2:0] == 3'h4)
		|=> msg_type_out == BCCW_TYPE_MODE)
		else $error("Format 100 decoded wrongly.");
	a_bcast_mode: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_IDLE && msg_start_in && ctrl_out[2:0] == 3'h6)
		|=> msg_type_out == BCCW_TYPE_BC_MODE)
		else $error("Format 110 decoded wrongly.");

	// Latched fields and the busy flag across a message.
	a_held_in_msg: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_BUSY && !msg_done_in) |=>
		$stable(msg_type_out) && $stable(r_reg.msg_done_irq_request))
		else $error("Latched format changed mid-message.");
	a_busy_at_start: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_IDLE && msg_start_in) |=> busy_out)
		else $error("Busy not raised at message start.");
	a_busy_ends: assert property (@(posedge mclk_in)
		disable iff (rst_in)
		(r_reg.state == BCCW_BUSY && msg_done_in) |=> !busy_out)
		else $error("Busy not dropped at message completion.");

endmodule : bccw_decode
`default_nettype wire

// ==== bccw_rt_model.sv ====
// Remote terminal model that answers a request with one status word.
`timescale 1ns/1ns
`default_nettype none
module bccw_rt_model (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic bcr_in,
	output logic status_valid_out,
	output logic [15:0] status_word_out
);
	logic [15:0] last_reg;
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			status_valid_out <= 1'b0;
			last_reg <= 16'h0000;
		end else begin
			status_valid_out <= req_in;
			if (req_in) begin
				last_reg <= {11'h2A5, bcr_in, 4'h3};
			end
		end
	end
	// A released word shows the inverse so stale data never matches.
	assign status_word_out = status_valid_out ? last_reg : ~last_reg;
endmodule : bccw_rt_model
`default_nettype wire

// ==== bc_message_control_word_format_decode_tb.sv ====
// Self-checking bench for the control word format decoder.
`timescale 1ns/1ns
`default_nettype none
module bc_message_control_word_format_decode_tb;
	import bccw_pkg::*;
	logic mclk_in = 0, rst_in = 1, wr = 0, st = 0, tr = 0;
	logic done = 0, req = 0, bcr = 0, sv, ext, sset, irq, busy;
	logic [15:0] cd = 16'h0000, cfg = 16'h0000, ien = 16'h0000, sw, co;
	logic [31:0] rnd = 32'h000172FF;
	logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
	bccw_type_t ty;
	int mismatches = 0, compares = 0, cyc = 0;
	bccw_decode uut (.mclk_in(mclk_in), .rst_in(rst_in), .ctrl_wr_in(wr),
		.ctrl_data_in(cd), .cfg_reg_in(cfg), .irq_en_reg_in(ien),
		.msg_start_in(st), .cmd_tr_in(tr), .status_valid_in(sv),
		.status_word_in(sw), .msg_done_in(done), .ctrl_out(co),
		.msg_type_out(ty), .ext_block_out(ext), .status_set_out(sset),
		.msg_done_irq_out(irq), .busy_out(busy));
	bccw_rt_model rt (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req),
		.bcr_in(bcr), .status_valid_out(sv), .status_word_out(sw));
	always #20 mclk_in = ~mclk_in;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [15:0] exp_type(input logic [2:0] f, input logic t);
		if (f == 3'h0) return t ? 16'h0001 : 16'h0000;
		if (f == 3'h6) return 16'h0006;
		return {13'h0000, f} + 16'h0001;
	endfunction : exp_type
	function automatic logic exp_set(input logic m, b5, s);
		return m ? (!b5 && s) : (b5 != s);
	endfunction : exp_set
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("mismatches=%0d compares=%0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic msg(input logic [15:0] c);
		@(posedge mclk_in);
		cfg <= rnd[31:16];
		ien <= rnd[27:12];
		wr <= 1'b1;
		cd <= c;
		@(posedge mclk_in);
		wr <= 1'b0;
		st <= 1'b1;
		tr <= rnd[7];
		@(posedge mclk_in);
		st <= 1'b0;
		wr <= 1'b1;
		cd <= c ^ 16'h0032;
		req <= 1'b1;
		bcr <= rnd[9];
		#1;
		check(co, c & 16'hFFF7);
		check({15'h0000, busy}, 16'h0001);
		check({13'h0000, ty}, exp_type(c[2:0], tr));
		check({15'h0000, ext}, {15'h0000, c[0]});
		@(posedge mclk_in);
		wr <= 1'b0;
		req <= 1'b0;
		repeat (2) @(posedge mclk_in);
		done <= 1'b1;
		@(posedge mclk_in);
		done <= 1'b0;
		#1;
		check({15'h0000, irq}, {15'h0000, c[4] & ien[3]});
		check(16'(sset), 16'(exp_set(cfg[0], c[5], bcr)));
		check({15'h0000, busy}, 16'h0000);
	endtask : msg
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		repeat (10) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		#1;
		check(co, BCCW_CTRL_RESET);
		for (int i = 0; i < 80; i++) begin
			rnd = lfsr(rnd);
			msg(i == 0 ? 16'hFFFE : {rnd[15:3], codes[rnd[2:0] % 6]});
		end
		stop_test();
	end
endmodule : bc_message_control_word_format_decode_tb
`default_nettype wire
